// >>> core/drsc_top.sv
// double-rate io cell with strobe capture, phase-shift references, capture fifo and axi4-lite slave
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps

module drsc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wr_ptr_reg;
	logic [PW:0]      rd_ptr_reg;
	wire              push;
	wire              pop;

	assign in_ready  = (wr_ptr_reg[PW] == rd_ptr_reg[PW]) || (wr_ptr_reg[PW-1:0] != rd_ptr_reg[PW-1:0]);
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign out_data  = mem[rd_ptr_reg[PW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_reg[PW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + (PW+1)'(push);
			rd_ptr_reg <= rd_ptr_reg + (PW+1)'(pop);
		end
	end
endmodule : drsc_fifo

module drsc_top (
	input  wire logic                              clock,
	input  wire logic                              rst,
	input  wire logic [drsc_pkg::AXI_AW-1:0]       s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [drsc_pkg::AXI_DW-1:0]       s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [drsc_pkg::AXI_AW-1:0]       s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [drsc_pkg::AXI_DW-1:0]            s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	input  wire logic [drsc_pkg::DQ_W-1:0]         dq_in,
	output logic [drsc_pkg::DQ_W-1:0]              dq_out,
	output logic [drsc_pkg::DQ_W-1:0]              dq_oe,
	output logic                                   io_clk_out,
	input  wire logic [drsc_pkg::N_DQS-1:0]        dqs_top_p,
	input  wire logic [drsc_pkg::N_DQS-1:0]        dqs_top_n,
	input  wire logic [drsc_pkg::N_DQS-1:0]        dqs_bot_p,
	input  wire logic [drsc_pkg::N_DQS-1:0]        dqs_bot_n,
	input  wire logic [drsc_pkg::N_REFPIN-1:0]     ref_top_clk,
	input  wire logic [drsc_pkg::N_REFPIN-1:0]     ref_bot_clk,
	input  wire logic                              pll5_clk,
	input  wire logic                              pll6_clk
);
	localparam int DQ_W = drsc_pkg::DQ_W;

	function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : wr_merge

	function automatic logic [DQ_W-1:0] lane_mask(input logic [1:0] wid);
		case (wid)
			drsc_pkg::WID_X4:  lane_mask = DQ_W'(36'h0_0000_000f);
			drsc_pkg::WID_X9:  lane_mask = DQ_W'(36'h0_0000_01ff);
			drsc_pkg::WID_X18: lane_mask = DQ_W'(36'h0_0003_ffff);
			default:           lane_mask = DQ_W'(36'hf_ffff_ffff);
		endcase
	endfunction : lane_mask

	// pin choices 0..3 map to the edge's four clock inputs; only the edge's own pll is reachable
	function automatic logic ref_pick(input logic [2:0] sel, input logic [3:0] pins, input logic pll);
		return (sel == drsc_pkg::REF_PLL) ? pll : ((sel < drsc_pkg::REF_PLL) ? pins[sel[1:0]] : 1'b0);
	endfunction : ref_pick

	function automatic logic [drsc_pkg::PER_W-1:0] sat_inc(input logic [drsc_pkg::PER_W-1:0] v);
		return (&v) ? v : v + 8'h01;
	endfunction : sat_inc

	// input synchronisers
	logic [drsc_pkg::SYNC_W-1:0] sync1_reg;
	logic [drsc_pkg::SYNC_W-1:0] sync2_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {dq_in, dqs_top_p, dqs_top_n, dqs_bot_p, dqs_bot_n, ref_top_clk, ref_bot_clk, pll5_clk, pll6_clk};
			sync2_reg <= sync1_reg;
		end
	end

	logic [DQ_W-1:0]                   dq_s;
	logic [drsc_pkg::N_DQS-1:0]        tp_s, tn_s, bp_s, bn_s;
	logic [3:0]                        rt_s, rb_s;
	logic                              p5_s, p6_s;
	assign {dq_s, tp_s, tn_s, bp_s, bn_s, rt_s, rb_s, p5_s, p6_s} = sync2_reg;

	// registers
	logic [31:0] ctrl_reg, inv_lo_reg, inv_hi_reg, tx_a_reg, tx_b_reg, tx_hi_reg;
	drsc_pkg::drsc_ctrl_t ctrl;
	assign ctrl = ctrl_reg;

	wire [DQ_W-1:0] mask     = lane_mask(ctrl.width);
	wire [DQ_W-1:0] dq_i     = dq_s ^ {inv_hi_reg[3:0], inv_lo_reg};
	wire            inv_stb  = inv_hi_reg[drsc_pkg::INV_HI_STROBE_BIT];
	wire            inv_ref  = inv_hi_reg[drsc_pkg::INV_HI_REF_BIT];
	wire            cap_on   = (ctrl.mode == drsc_pkg::MODE_IN) || (ctrl.mode == drsc_pkg::MODE_BIDIR);
	wire            drv_on   = (ctrl.mode == drsc_pkg::MODE_OUT) || (ctrl.mode == drsc_pkg::MODE_BIDIR);

	// phase-shift references: period measured in system cycles, tap is a quarter period
	wire ref_t = ref_pick(ctrl.tref, rt_s, p5_s) ^ inv_ref;
	wire ref_b = ref_pick(ctrl.bref, rb_s, p6_s) ^ inv_ref;
	logic ref_t_prev_reg, ref_b_prev_reg;
	logic [drsc_pkg::PER_W-1:0] cnt_t_reg, cnt_b_reg, per_t_reg, per_b_reg;
	wire ref_t_rise = ref_t && !ref_t_prev_reg;
	wire ref_b_rise = ref_b && !ref_b_prev_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_t_prev_reg <= 1'b0;
			ref_b_prev_reg <= 1'b0;
			cnt_t_reg      <= '0;
			cnt_b_reg      <= '0;
			per_t_reg      <= '0;
			per_b_reg      <= '0;
		end else begin
			ref_t_prev_reg <= ref_t;
			ref_b_prev_reg <= ref_b;
			cnt_t_reg      <= ref_t_rise ? '0 : sat_inc(cnt_t_reg);
			cnt_b_reg      <= ref_b_rise ? '0 : sat_inc(cnt_b_reg);
			if (ref_t_rise) begin
				per_t_reg <= sat_inc(cnt_t_reg);
			end
			if (ref_b_rise) begin
				per_b_reg <= sat_inc(cnt_b_reg);
			end
		end
	end

	// strobe selection: indices 0..9 on one side of the reference, 10..17 on the other
	wire       idx_ok = ctrl.idx < 5'(drsc_pkg::N_DQS);
	wire [4:0] idx    = idx_ok ? ctrl.idx : 5'h00;
	wire       stb_p  = ctrl.edge_bot ? bp_s[idx] : tp_s[idx];
	wire       stb_n  = ctrl.edge_bot ? bn_s[idx] : tn_s[idx];
	wire [drsc_pkg::PER_W-1:0] per_sel = ctrl.edge_bot ? per_b_reg : per_t_reg;
	wire [drsc_pkg::TAP_W-1:0] tap     = per_sel[drsc_pkg::PER_W-1:2];

	logic                          stb_lvl_reg;
	logic [drsc_pkg::DLY_DEPTH-1:0] dly_line_reg;
	logic                          dly_prev_reg;
	wire                           stb_dly  = dly_line_reg[tap];
	wire                           stb_rise = stb_dly && !dly_prev_reg;
	wire                           stb_fall = !stb_dly && dly_prev_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stb_lvl_reg  <= 1'b0;
			dly_line_reg <= '0;
			dly_prev_reg <= 1'b0;
		end else begin
			// a pair with equal legs is not a valid differential level, so the last level is kept
			if (idx_ok && (stb_p != stb_n)) begin
				stb_lvl_reg <= stb_p ^ inv_stb;
			end
			dly_line_reg <= {dly_line_reg[drsc_pkg::DLY_DEPTH-2:0], stb_lvl_reg};
			dly_prev_reg <= stb_dly;
		end
	end

	// capture registers run on the system clock and load only on delayed strobe edges
	logic [DQ_W-1:0] cap_a_reg, cap_b_reg, hold_reg;
	logic            pair_evt_reg;
	logic            push_valid_reg;
	drsc_pkg::drsc_pair_t push_data_reg;
	logic            overrun_reg;
	wire             fifo_in_ready;
	wire             fifo_out_valid;
	drsc_pkg::drsc_pair_t fifo_out;
	wire             pop;
	logic            ovr_clr;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cap_a_reg    <= '0;
			cap_b_reg    <= '0;
			hold_reg     <= '0;
			pair_evt_reg <= 1'b0;
		end else begin
			pair_evt_reg <= cap_on && stb_fall;
			if (cap_on && stb_rise) begin
				cap_a_reg <= dq_i & mask;
			end
			if (cap_on && stb_fall) begin
				cap_b_reg <= dq_i & mask;
				hold_reg  <= cap_a_reg;
			end
		end
	end

	// back-pressure: a pair waits for fifo room; a newer pair arriving meanwhile is lost and flagged
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			push_valid_reg <= 1'b0;
			push_data_reg  <= '0;
			overrun_reg    <= 1'b0;
		end else begin
			if (pair_evt_reg && (!push_valid_reg || fifo_in_ready)) begin
				push_valid_reg <= 1'b1;
				push_data_reg  <= '{a: hold_reg, b: cap_b_reg};
			end else if (fifo_in_ready) begin
				push_valid_reg <= 1'b0;
			end
			if (pair_evt_reg && push_valid_reg && !fifo_in_ready) begin
				overrun_reg <= 1'b1;
			end else if (ovr_clr) begin
				overrun_reg <= 1'b0;
			end
		end
	end

	drsc_fifo #(
		.WIDTH ($bits(drsc_pkg::drsc_pair_t)),
		.DEPTH (drsc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (push_valid_reg),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data_reg),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  (fifo_out)
	);

	// launch side: io clock is the system clock halved
	logic            phase_reg;
	// dq_out itself holds the first bit, so only the second bit needs a register of its own
	logic [DQ_W-1:0] out_b_reg;
	logic            oe_n_reg;
	wire [DQ_W-1:0]  tx_a   = {tx_hi_reg[3:0], tx_a_reg} & mask;
	wire [DQ_W-1:0]  tx_b   = {tx_hi_reg[7:4], tx_b_reg} & mask;
	wire             io_rise = !phase_reg;
	wire             oe_upd  = (ctrl.mode == drsc_pkg::MODE_BIDIR) ? phase_reg : io_rise;
	wire             oe_n_next = oe_upd ? !(drv_on && ctrl.oe_req) : oe_n_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_reg  <= 1'b0;
			io_clk_out <= 1'b0;
			out_b_reg  <= '0;
			dq_out     <= '0;
			oe_n_reg   <= 1'b1;
			dq_oe      <= '0;
		end else begin
			phase_reg  <= !phase_reg;
			io_clk_out <= !phase_reg;
			if (io_rise) begin
				out_b_reg <= tx_b;
			end
			dq_out   <= io_rise ? tx_a : out_b_reg;
			oe_n_reg <= oe_n_next;
			// a width change must not move the pin enables off the allowed edge either
			if (oe_upd) begin
				dq_oe <= {DQ_W{!oe_n_next}} & mask;
			end
		end
	end

	// axi4-lite write side
	drsc_pkg::drsc_wr_state_t wr_state_reg;
	logic                     aw_hold_reg, w_hold_reg;
	logic [drsc_pkg::AXI_AW-1:0] awaddr_reg;
	logic [31:0]              wdata_reg;
	logic [3:0]               wstrb_reg;
	wire aw_hs  = s_axi_awvalid && s_axi_awready;
	wire w_hs   = s_axi_wvalid && s_axi_wready;
	wire wr_go  = (wr_state_reg == drsc_pkg::DRSC_WR_IDLE) && aw_hold_reg && w_hold_reg;
	wire wa_ctrl = awaddr_reg == drsc_pkg::OFS_CTRL;
	wire wa_ilo  = awaddr_reg == drsc_pkg::OFS_INV_LO;
	wire wa_ihi  = awaddr_reg == drsc_pkg::OFS_INV_HI;
	wire wa_txa  = awaddr_reg == drsc_pkg::OFS_TX_A;
	wire wa_txb  = awaddr_reg == drsc_pkg::OFS_TX_B;
	wire wa_txh  = awaddr_reg == drsc_pkg::OFS_TX_HI;
	wire wa_stat = awaddr_reg == drsc_pkg::OFS_STATUS;
	wire wa_rx   = (awaddr_reg == drsc_pkg::OFS_RX_A) || (awaddr_reg == drsc_pkg::OFS_RX_B) ||
	               (awaddr_reg == drsc_pkg::OFS_RX_HI);
	wire wa_ok   = wa_ctrl || wa_ilo || wa_ihi || wa_txa || wa_txb || wa_txh || wa_stat || wa_rx;
	assign ovr_clr = wr_go && wa_stat && wstrb_reg[3] && wdata_reg[drsc_pkg::STAT_OVR_BIT];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_state_reg  <= drsc_pkg::DRSC_WR_IDLE;
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			awaddr_reg    <= '0;
			wdata_reg     <= '0;
			wstrb_reg     <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= drsc_pkg::RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_hold_reg   <= 1'b1;
				awaddr_reg    <= {s_axi_awaddr[drsc_pkg::AXI_AW-1:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (w_hs) begin
				w_hold_reg   <= 1'b1;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			case (wr_state_reg)
				drsc_pkg::DRSC_WR_IDLE: begin
					if (wr_go) begin
						aw_hold_reg  <= 1'b0;
						w_hold_reg   <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wa_ok ? drsc_pkg::RESP_OKAY : drsc_pkg::RESP_SLVERR;
						wr_state_reg <= drsc_pkg::DRSC_WR_RESP;
					end
				end
				drsc_pkg::DRSC_WR_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid  <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready  <= 1'b1;
						wr_state_reg  <= drsc_pkg::DRSC_WR_IDLE;
					end
				end
				default: begin
					wr_state_reg <= drsc_pkg::DRSC_WR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_reg   <= drsc_pkg::CTRL_RST;
			inv_lo_reg <= drsc_pkg::INV_RST;
			inv_hi_reg <= drsc_pkg::INV_RST;
			tx_a_reg   <= drsc_pkg::TX_RST;
			tx_b_reg   <= drsc_pkg::TX_RST;
			tx_hi_reg  <= drsc_pkg::TX_RST;
		end else if (wr_go) begin
			if (wa_ctrl) ctrl_reg   <= wr_merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0001_ffff;
			if (wa_ilo)  inv_lo_reg <= wr_merge(inv_lo_reg, wdata_reg, wstrb_reg);
			if (wa_ihi)  inv_hi_reg <= wr_merge(inv_hi_reg, wdata_reg, wstrb_reg) & 32'h0000_003f;
			if (wa_txa)  tx_a_reg   <= wr_merge(tx_a_reg, wdata_reg, wstrb_reg);
			if (wa_txb)  tx_b_reg   <= wr_merge(tx_b_reg, wdata_reg, wstrb_reg);
			if (wa_txh)  tx_hi_reg  <= wr_merge(tx_hi_reg, wdata_reg, wstrb_reg) & 32'h0000_00ff;
		end
	end

	// axi4-lite read side; reading the high rx word pops the head pair
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire [drsc_pkg::AXI_AW-1:0] ra = {s_axi_araddr[drsc_pkg::AXI_AW-1:2], 2'b00};
	wire [31:0] stat_word = {5'h00, overrun_reg, !fifo_in_ready, !fifo_out_valid, 2'b00, tap, per_b_reg, per_t_reg};
	wire [31:0] rx_hi_word = fifo_out_valid ? {24'h00_0000, fifo_out.b[35:32], fifo_out.a[35:32]} : 32'h0000_0000;
	wire [31:0] rx_a_word  = fifo_out_valid ? fifo_out.a[31:0] : 32'h0000_0000;
	wire [31:0] rx_b_word  = fifo_out_valid ? fifo_out.b[31:0] : 32'h0000_0000;
	wire        ra_ok = (ra <= drsc_pkg::OFS_RX_HI);
	wire [31:0] rd_mux =
		(ra == drsc_pkg::OFS_CTRL)   ? ctrl_reg   :
		(ra == drsc_pkg::OFS_INV_LO) ? inv_lo_reg :
		(ra == drsc_pkg::OFS_INV_HI) ? inv_hi_reg :
		(ra == drsc_pkg::OFS_TX_A)   ? tx_a_reg   :
		(ra == drsc_pkg::OFS_TX_B)   ? tx_b_reg   :
		(ra == drsc_pkg::OFS_TX_HI)  ? tx_hi_reg  :
		(ra == drsc_pkg::OFS_STATUS) ? stat_word  :
		(ra == drsc_pkg::OFS_RX_A)   ? rx_a_word  :
		(ra == drsc_pkg::OFS_RX_B)   ? rx_b_word  :
		(ra == drsc_pkg::OFS_RX_HI)  ? rx_hi_word : 32'h0000_0000;
	assign pop = ar_hs && (ra == drsc_pkg::OFS_RX_HI) && fifo_out_valid;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= drsc_pkg::RESP_OKAY;
		end else begin
			if (ar_hs) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_mux;
				s_axi_rresp   <= ra_ok ? drsc_pkg::RESP_OKAY : drsc_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule : drsc_top

// >>> core/drsc_pkg.sv
// shared constants and types for the double-rate strobe capture cell
package drsc_pkg;
	localparam int DQ_W       = 36;
	localparam int AXI_AW     = 8;
	localparam int AXI_DW     = 32;
	localparam int FIFO_DEPTH = 8;
	localparam int DLY_DEPTH  = 64;
	localparam int TAP_W      = 6;
	localparam int PER_W      = 8;
	localparam int N_DQS      = 18;
	localparam int N_DQS_RIGHT = 10;
	localparam int N_REFPIN   = 4;
	localparam int SYNC_W     = DQ_W + 4 * N_DQS + 2 * N_REFPIN + 2;

	localparam logic [AXI_AW-1:0] OFS_CTRL   = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_INV_LO = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_INV_HI = 8'h08;
	localparam logic [AXI_AW-1:0] OFS_TX_A   = 8'h0c;
	localparam logic [AXI_AW-1:0] OFS_TX_B   = 8'h10;
	localparam logic [AXI_AW-1:0] OFS_TX_HI  = 8'h14;
	localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h18;
	localparam logic [AXI_AW-1:0] OFS_RX_A   = 8'h1c;
	localparam logic [AXI_AW-1:0] OFS_RX_B   = 8'h20;
	localparam logic [AXI_AW-1:0] OFS_RX_HI  = 8'h24;

	localparam logic [1:0] MODE_IN    = 2'h0;
	localparam logic [1:0] MODE_OUT   = 2'h1;
	localparam logic [1:0] MODE_BIDIR = 2'h2;
	localparam logic [1:0] WID_X4     = 2'h0;
	localparam logic [1:0] WID_X9     = 2'h1;
	localparam logic [1:0] WID_X18    = 2'h2;
	localparam logic [1:0] WID_X36    = 2'h3;
	localparam logic [2:0] REF_PLL    = 3'h4;

	localparam int INV_HI_STROBE_BIT = 4;
	localparam int INV_HI_REF_BIT    = 5;
	localparam int STAT_TAP_LSB      = 16;
	localparam int STAT_EMPTY_BIT    = 24;
	localparam int STAT_FULL_BIT     = 25;
	localparam int STAT_OVR_BIT      = 26;

	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] INV_RST  = 32'h0000_0000;
	localparam logic [31:0] TX_RST   = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [DQ_W-1:0] a;
		logic [DQ_W-1:0] b;
	} drsc_pair_t;

	typedef struct packed {
		logic [14:0] unused;
		logic [2:0]  bref;
		logic [2:0]  tref;
		logic [4:0]  idx;
		logic        edge_bot;
		logic [1:0]  width;
		logic        oe_req;
		logic [1:0]  mode;
	} drsc_ctrl_t;

	typedef enum logic [1:0] {
		DRSC_WR_IDLE = 2'b01,
		DRSC_WR_RESP = 2'b10
	} drsc_wr_state_t;
endpackage : drsc_pkg

// >>> verification/drsc_checker_assertions.sv
// port assertions for the strobe capture cell
`timescale 1ns/100ps
module drsc_checker (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        io_clk_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		!s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
	endsequence
	a_wr_answer: assert property (s_wr_taken |=> s_wr_answer) else $error("write response not one cycle late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not freed");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not freed");
	a_io_clk_fall: assert property (io_clk_out |=> !io_clk_out) else $error("io clock high too long");
	a_io_clk_rise: assert property (!io_clk_out |=> io_clk_out) else $error("io clock low too long");
endmodule : drsc_checker
bind drsc_top drsc_checker u_chk (.clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .io_clk_out);

// >>> verification/drsc_mem_model.sv
// behavioural external memory: strobe, data and free-running reference clocks
`timescale 1ns/100ps
module drsc_mem_model (
	output logic [35:0] dq,
	output logic [17:0] dqs_p,
	output logic [17:0] dqs_n,
	output logic [3:0]  ref_clk,
	output logic        pll_clk
);
	initial begin
		dq = '0;
		dqs_p = '0;
		dqs_n = '1;
		ref_clk = '0;
		pll_clk = 1'b0;
		forever begin
			#80 ref_clk = ~ref_clk;
			pll_clk = ~pll_clk;
		end
	end
	// data is held long past each edge since the cell adds sync latency ahead of its delay
	task automatic burst(input drsc_pkg::drsc_pair_t p);
		dq = p.a;
		#40 dqs_p[0] = 1'b1;
		dqs_n[0] = 1'b0;
		#80 dqs_p[0] = 1'b0;
		dqs_n[0] = 1'b1;
		#30 dq = p.b;
		#110 dq = ~p.b;
	endtask : burst
endmodule : drsc_mem_model

// >>> verification/testbench.sv
// self-checking bench for the strobe capture cell
`timescale 1ns/100ps
module testbench;
	logic        clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, io_clk_out, pll_clk;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [35:0] dq_out, dq_oe, mem_dq;
	logic [17:0] dqs_p, dqs_n;
	logic [3:0]  ref_clk;
	int          n_errors, comparisons;
	wire  logic [35:0] dq_pin = (dq_oe & dq_out) | (~dq_oe & mem_dq);

	drsc_top uut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dq_in(dq_pin), .dq_out, .dq_oe,
		.io_clk_out, .dqs_top_p(dqs_p), .dqs_top_n(dqs_n), .dqs_bot_p(18'h0_0000), .dqs_bot_n(18'h3_ffff),
		.ref_top_clk(ref_clk), .ref_bot_clk(ref_clk), .pll5_clk(pll_clk), .pll6_clk(pll_clk));
	drsc_mem_model mem (.dq(mem_dq), .dqs_p, .dqs_n, .ref_clk, .pll_clk);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic finish_test;
		if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : finish_test

	// requests are set just after an edge and each is held until its own ready is sampled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rv = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rv, e);
	endtask : rc

	task automatic t_regs;
		rd(drsc_pkg::OFS_STATUS);
		for (int i = 0; i < 40 && rv[7:0] != 8'h08; i++) rd(drsc_pkg::OFS_STATUS);
		rc(drsc_pkg::OFS_STATUS, 32'h0102_0808);
		rc(drsc_pkg::OFS_RX_A, 32'h0);
		rd(8'h40);
		chk({rs, rv}, {drsc_pkg::RESP_SLVERR, 32'h0});
		wr(8'h40, '1);
		chk(rs, drsc_pkg::RESP_SLVERR);
		rc(drsc_pkg::OFS_INV_HI, drsc_pkg::INV_RST);
		rc(drsc_pkg::OFS_TX_B, drsc_pkg::TX_RST);
		wr(drsc_pkg::OFS_CTRL, '1);
		rc(drsc_pkg::OFS_CTRL, 32'h0001_ffff);
	endtask : t_regs

	// the pair is read back only once it has landed in the buffer
	task automatic t_cap(input drsc_pkg::drsc_pair_t p, input logic [35:0] inv);
		mem.burst(p);
		rd(drsc_pkg::OFS_STATUS);
		for (int i = 0; i < 10 && rv[24]; i++) rd(drsc_pkg::OFS_STATUS);
		rc(drsc_pkg::OFS_RX_A, p.a[31:0] ^ inv[31:0]);
		rc(drsc_pkg::OFS_RX_B, p.b[31:0] ^ inv[31:0]);
		rc(drsc_pkg::OFS_RX_HI, {24'h0, p.b[35:32] ^ inv[35:32], p.a[35:32] ^ inv[35:32]});
	endtask : t_cap

	task automatic wait_oe(input logic [35:0] e, input logic io);
		for (int i = 0; i < 12 && dq_oe !== e; i++) begin
			@(posedge clock);
			#1;
		end
		chk(dq_oe, e);
		chk(io_clk_out, io);
	endtask : wait_oe

	task automatic t_tx;
		wr(drsc_pkg::OFS_TX_A, 32'h1234_5678);
		wr(drsc_pkg::OFS_TX_B, 32'h9abc_def0);
		wr(drsc_pkg::OFS_TX_HI, 32'h0000_00c3);
		fork
			wr(drsc_pkg::OFS_CTRL, 32'h0000_001d);
			wait_oe('1, 1'b1);
		join
		@(posedge io_clk_out);
		#1;
		chk(dq_out, 36'h3_1234_5678);
		@(posedge clock);
		#1;
		chk(dq_out, 36'hc_9abc_def0);
		fork
			wr(drsc_pkg::OFS_CTRL, 32'h0000_000d);
			wait_oe(36'h0_0000_01ff, 1'b1);
		join
		// bidirectional turn-on must wait for the falling io clock edge
		fork
			wr(drsc_pkg::OFS_CTRL, 32'h0000_001e);
			wait_oe('1, 1'b0);
		join
		fork
			wr(drsc_pkg::OFS_CTRL, 32'h0000_001a);
			wait_oe('0, 1'b0);
		join
	endtask : t_tx

	// ten pairs with no reads: eight fill the buffer, one waits, the last is lost
	task automatic t_fifo;
		int n;
		wr(drsc_pkg::OFS_CTRL, 32'h0000_0018);
		for (int i = 0; i < 10; i++) mem.burst('{a: 36'(i), b: ~36'(i)});
		// the last pair is still in the capture pipeline when the burst returns
		repeat (4) @(posedge clock);
		rd(drsc_pkg::OFS_STATUS);
		chk(rv[26:24], 3'b110);
		wr(drsc_pkg::OFS_STATUS, 32'h0400_0000);
		rd(drsc_pkg::OFS_STATUS);
		chk(rv[26:24], 3'b010);
		n = 0;
		while (!rv[24] && n < 12) begin
			rc(drsc_pkg::OFS_RX_A, 32'(n));
			rc(drsc_pkg::OFS_RX_HI, 32'h0000_00f0);
			n++;
			rd(drsc_pkg::OFS_STATUS);
		end
		chk(n, 9);
	endtask : t_fifo

	initial begin
		rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_regs;
		wr(drsc_pkg::OFS_CTRL, 32'h0000_0018);
		t_cap('{a: 36'h5_a5a5_0ff0, b: 36'ha_5a5a_f00f}, '0);
		wr(drsc_pkg::OFS_INV_LO, 32'hffff_ffff);
		wr(drsc_pkg::OFS_INV_HI, 32'h0000_000a);
		t_cap('{a: 36'h1_2345_6789, b: 36'h8_7654_3210}, 36'ha_ffff_ffff);
		wr(drsc_pkg::OFS_INV_LO, 32'h0);
		wr(drsc_pkg::OFS_INV_HI, 32'h0);
		t_tx;
		t_cap('{a: 36'hf_0000_ffff, b: 36'h0_ffff_0000}, '0);
		t_fifo;
		finish_test;
	end

	initial begin
		#60us;
		n_errors++;
		finish_test;
	end
endmodule : testbench
